// [logic/evb_exception_vector_base.sv]
// Exception vector base register and vector address formation
`include "evb_map.svh"
`default_nettype none
module evb_exception_vector_base #(
	parameter bit        WG_PRESENT = 1'b0,           // Write-gate option built in
	parameter bit        MERGE_OR   = 1'b0,           // Merge offset into register base by OR, not add
	parameter int        OFFSET_W   = 16,             // Exception offset width
	parameter logic [31:0] BOOT_BASE  = 32'hbfc0_0000, // Boot vector default base
	parameter logic [31:0] DEBUG_BASE = 32'hbfc0_0000  // Debug vector default base
) (
	input  wire logic                  clk_sys_i,          // System clock, 40 MHz
	input  wire logic                  rstn_i,             // Async reset, active low
	// Coprocessor register port
	input  wire logic                  cop_wr_en_i,        // Register write strobe
	input  wire logic                  cop_rd_en_i,        // Register read strobe
	input  wire logic [4:0]            cop_reg_i,          // Register number
	input  wire logic [2:0]            cop_sel_i,          // Register select
	input  wire logic [31:0]           cop_wr_data_i,      // Write data
	output logic      [31:0]           cop_rd_data_o,      // Read data, next cycle
	// Hardware register read
	input  wire logic                  hwr_rd_en_i,        // Hardware read strobe
	input  wire logic [4:0]            hwr_num_i,          // Hardware register number
	output logic      [31:0]           hwr_rd_data_o,      // Hardware read data
	// Preset strap
	input  wire logic [9:0]            processor_number_i, // Processor number pins
	// Core exception logic
	input  wire logic                  exc_req_i,          // Vector request
	input  wire logic                  boot_vector_select_i, // Boot vector select
	input  wire logic                  exc_debug_i,        // Debug exception
	input  wire logic                  exc_cache_err_i,    // Cache error exception
	input  wire logic [OFFSET_W-1:0]   exc_offset_i,       // Vector offset
	output logic                       vec_valid_o,        // Vector address valid
	output evb_pkg::evb_vec_kind_t     vec_kind_o,         // Source of the vector
	output logic      [31:0]           vec_addr_o          // Vector address
);

	// ==========================================
	// Parameter check
	if (OFFSET_W < 12 || OFFSET_W > 29) begin : g_bad_offset_w
		$error("OFFSET_W must lie between 12 and 29");
	end

	// ==========================================
	// Strap synchroniser
	logic [9:0] pnum_sync;

	evb_sync #(
		.W (10)
	) u_pnum_sync (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.async_i   (processor_number_i),
		.sync_o    (pnum_sync)
	);

	// ==========================================
	// Register decode and read value
	logic        reg_hit;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] reg_view;

	logic [19:0] base_r;
	logic [19:0] base_nxt;
	logic        wg_r;
	logic        wg_nxt;

	assign reg_hit = (cop_reg_i == `EVB_REG_NUM) && (cop_sel_i == `EVB_REG_SEL);
	assign wr_hit  = cop_wr_en_i && reg_hit;
	assign rd_hit  = cop_rd_en_i && reg_hit;

	always_comb begin
		reg_view = '0;
		reg_view[31:`EVB_BASE_LSB] = base_r;
		reg_view[`EVB_WG_BIT] = WG_PRESENT ? wg_r : 1'b0; // RULE_10
		reg_view[`EVB_RSV_BIT] = 1'b0; // RULE_10
		reg_view[`EVB_PNUM_MSB:0] = pnum_sync; // RULE_11
	end

	// ==========================================
	// Base register
	always_comb begin
		base_nxt = base_r;
		wg_nxt   = wg_r;
		if (wr_hit) begin
			base_nxt[17:0] = cop_wr_data_i[29:`EVB_BASE_LSB];
			if (WG_PRESENT) begin
				wg_nxt = cop_wr_data_i[`EVB_WG_BIT]; // RULE_09
				if (cop_wr_data_i[`EVB_WG_BIT]) begin
					base_nxt[19:18] = cop_wr_data_i[31:30]; // RULE_07
				end
			end else begin
				base_nxt[19:18] = `EVB_LEGACY_HI; // RULE_04
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			base_r <= `EVB_BASE_RST; // RULE_03
			wg_r   <= 1'b0; // RULE_09
		end else begin
			base_r <= base_nxt;
			wg_r   <= wg_nxt;
		end
	end

	// ==========================================
	// Read ports
	logic [31:0] rd_data_r;
	logic [31:0] rd_data_nxt;
	logic [31:0] hwr_data_r;
	logic [31:0] hwr_data_nxt;

	always_comb begin
		rd_data_nxt  = rd_data_r;
		hwr_data_nxt = hwr_data_r;
		if (rd_hit) begin
			rd_data_nxt = reg_view;
		end
		if (hwr_rd_en_i) begin
			hwr_data_nxt = '0;
			if (hwr_num_i == `EVB_HWR_PNUM) begin
				hwr_data_nxt[`EVB_PNUM_MSB:0] = pnum_sync; // RULE_11
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_r  <= '0;
			hwr_data_r <= '0;
		end else begin
			rd_data_r  <= rd_data_nxt;
			hwr_data_r <= hwr_data_nxt;
		end
	end

	assign cop_rd_data_o = rd_data_r;
	assign hwr_rd_data_o = hwr_data_r;

	// ==========================================
	// Vector address formation
	logic [31:0] vec_base;
	logic [29:0] off_ext;
	logic [29:0] low_sum;
	logic [31:0] dflt_sum;
	logic [31:0] vec_addr_nxt;
	logic [31:0] vec_addr_r;
	logic        vec_valid_r;
	logic        vec_valid_nxt;
	evb_pkg::evb_vec_kind_t vec_kind_r;
	evb_pkg::evb_vec_kind_t vec_kind_nxt;

	assign off_ext = {{(30 - OFFSET_W){1'b0}}, exc_offset_i};

	always_comb begin
		vec_base = {base_r, 12'h000}; // RULE_01
		if (WG_PRESENT) begin
			vec_base[29] = base_r[17] | exc_cache_err_i; // RULE_08 RULE_06
		end else begin
			vec_base[31:29] = exc_cache_err_i ? `EVB_SEG_CACHE : `EVB_SEG_NORMAL; // RULE_13
		end
	end

	// Low 30 bits only, so bit 29 never carries into bit 30
	always_comb begin
		if (MERGE_OR) begin
			low_sum = vec_base[29:0] | off_ext; // RULE_17
		end else begin
			low_sum = vec_base[29:0] + off_ext; // RULE_05 RULE_17
		end
	end

	assign dflt_sum = (exc_debug_i ? DEBUG_BASE : BOOT_BASE) + {2'b00, off_ext};

	always_comb begin
		vec_valid_nxt = exc_req_i; // RULE_18
		vec_kind_nxt  = vec_kind_r;
		vec_addr_nxt  = vec_addr_r;
		if (exc_req_i) begin
			if (exc_debug_i) begin
				vec_kind_nxt = evb_pkg::EVB_VK_DEBUG; // RULE_02
				vec_addr_nxt = dflt_sum;
			end else if (boot_vector_select_i) begin
				vec_kind_nxt = evb_pkg::EVB_VK_BOOT; // RULE_02
				vec_addr_nxt = dflt_sum;
			end else begin
				vec_kind_nxt = evb_pkg::EVB_VK_BASE;
				vec_addr_nxt = {vec_base[31:30], low_sum}; // RULE_05
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vec_valid_r <= 1'b0;
			vec_kind_r  <= evb_pkg::EVB_VK_BOOT;
			vec_addr_r  <= '0;
		end else begin
			vec_valid_r <= vec_valid_nxt;
			vec_kind_r  <= vec_kind_nxt;
			vec_addr_r  <= vec_addr_nxt;
		end
	end

	assign vec_valid_o = vec_valid_r;
	assign vec_kind_o  = vec_kind_r;
	assign vec_addr_o  = vec_addr_r;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	logic base_req;
	assign base_req = exc_req_i && !boot_vector_select_i && !exc_debug_i;

	a_base_low_zero: assert property ( // RULE_01
		base_req && (exc_offset_i == '0) && !exc_cache_err_i |=>
			vec_valid_o && (vec_kind_o == evb_pkg::EVB_VK_BASE)
			&& (vec_addr_o[11:0] == 12'h000)
			&& (vec_addr_o[28:12] == $past(base_r[16:0])))
		else $error("Base vector not formed from register");

	a_default_vector: assert property ( // RULE_02
		exc_req_i && (boot_vector_select_i || exc_debug_i) |=>
			(vec_kind_o != evb_pkg::EVB_VK_BASE)
			&& (vec_addr_o == $past(dflt_sum)))
		else $error("Default vector not taken");

	a_legacy_top: assert property ( // RULE_04
		!WG_PRESENT && rd_hit |=> cop_rd_data_o[31:30] == `EVB_LEGACY_HI)
		else $error("Fixed top bits not read as 10");

	a_carry_stop: assert property ( // RULE_05
		base_req |=>
			vec_addr_o[31:30] == $past(base_r[19:18]))
		else $error("Carry leaked into bit 30");

	// Large offsets may carry out of bit 28 and clear bit 29
	a_cache_seg: assert property ( // RULE_06
		base_req && exc_cache_err_i && (off_ext[29:12] == '0) |=>
			vec_addr_o[29])
		else $error("Cache error base bit 29 not set");

	a_wg_hold: assert property ( // RULE_07
		WG_PRESENT && wr_hit && !cop_wr_data_i[`EVB_WG_BIT] |=>
			$stable(base_r[19:18]))
		else $error("Top bits changed with gate clear");

	// Read two cycles after the write, no write between
	a_wg_readback: assert property ( // RULE_09
		WG_PRESENT && wr_hit ##1 !wr_hit ##1 rd_hit |=>
			cop_rd_data_o[`EVB_WG_BIT] == $past(cop_wr_data_i[`EVB_WG_BIT], 3))
		else $error("Gate bit did not read back");

	a_rsvd_zero: assert property ( // RULE_10
		rd_hit |=> !cop_rd_data_o[`EVB_RSV_BIT]
			&& (WG_PRESENT || !cop_rd_data_o[`EVB_WG_BIT]))
		else $error("Reserved bit read as one");

	a_pnum_hwr: assert property ( // RULE_11
		hwr_rd_en_i && (hwr_num_i == `EVB_HWR_PNUM) |=>
			hwr_rd_data_o == {22'h0, $past(pnum_sync)})
		else $error("Hardware read lost processor number");

	a_req_latency: assert property ( // RULE_18
		exc_req_i |=> vec_valid_o ##1 (vec_valid_o == $past(exc_req_i)))
		else $error("Vector valid not one cycle after request");

	// Field and form checks
	a_legacy_form: assert property ( // RULE_13
		!WG_PRESENT && base_req && (off_ext[29:12] == '0) |=>
			(vec_addr_o[31:29] == ($past(exc_cache_err_i) ? `EVB_SEG_CACHE : `EVB_SEG_NORMAL))
			&& (vec_addr_o[28:12] == $past(base_r[16:0])))
		else $error("Legacy segment form not kept");

	a_full_base: assert property ( // RULE_08
		WG_PRESENT && base_req && !exc_cache_err_i && (off_ext[29:12] == '0) |=>
			vec_addr_o[31:12] == $past(base_r))
		else $error("Gated vector not built from all base bits");

	a_wg_write: assert property ( // RULE_07
		WG_PRESENT && wr_hit && cop_wr_data_i[`EVB_WG_BIT] |=>
			base_r == $past(cop_wr_data_i[31:`EVB_BASE_LSB]))
		else $error("Gated write did not land");

	a_legacy_fixed: assert property ( // RULE_04
		!WG_PRESENT && wr_hit |=> base_r[19:18] == `EVB_LEGACY_HI)
		else $error("Fixed top bits changed by write");

	a_pnum_read: assert property ( // RULE_11
		rd_hit |=>
			cop_rd_data_o[`EVB_PNUM_MSB:0] == $past(pnum_sync))
		else $error("Register read lost processor number");

	a_hwr_other: assert property ( // RULE_11
		hwr_rd_en_i && (hwr_num_i != `EVB_HWR_PNUM) |=>
			hwr_rd_data_o == 32'h0000_0000)
		else $error("Other hardware read not zero");

	a_boot_kind: assert property ( // RULE_02
		exc_req_i && boot_vector_select_i && !exc_debug_i |=>
			vec_kind_o == evb_pkg::EVB_VK_BOOT)
		else $error("Boot vector kind not reported");

	a_debug_kind: assert property ( // RULE_02
		exc_req_i && exc_debug_i |=> vec_kind_o == evb_pkg::EVB_VK_DEBUG)
		else $error("Debug vector kind not reported");

endmodule // evb_exception_vector_base
`default_nettype wire

// [logic/evb_map.svh]
// Register layout, reset values and field positions of the exception vector base
// How it works
// RULE_01: Boot select clear: vector base is register bits 31..12 with zero low bits.
// RULE_02: Boot select set or debug exception: fixed default base, register ignored.
// RULE_03: Reset loads base bits 31..12 so the exception base is 0x8000_0000.
// RULE_04: No write gate: bits 31..30 fixed at 0b10, writes to them ignored.
// RULE_05: Offset addition never carries from bit 29 into bit 30.
// RULE_06: Cache error exceptions force bit 29 of the base to one.
// RULE_07: With write gate, bits 31..30 change only when written gate bit is one.
// RULE_08: With write gate, all base bits 31..12 form the vector.
// RULE_09: Gate bit 11 is read/write, resets to zero, reads back what was written.
// RULE_10: Bit 10, and bits 11..10 without gate, read zero; software writes zero.
// RULE_11: Processor number bits 9..0 read-only from hardware, also hardware read 0.
// RULE_12: Software changes the base only while boot select is one.
// RULE_13: Legacy form: top bits 0b100 normal, 0b101 cache error, then base 28..12.
// RULE_14: Software clears base bits 15..12 overlapped by large vectored offsets.
// RULE_15: Which of those bits must be zero depends on spacing and vector number.
// RULE_16: At 32 or zero byte spacing no base bits need clearing.
// RULE_17: Base and offset may be merged by addition or by bitwise OR.
// RULE_18: Offset, cache error and debug are taken with the vector request.
`ifndef EVB_MAP_SVH
`define EVB_MAP_SVH

// ==========================================
// Register address
`define EVB_REG_NUM    5'd15
`define EVB_REG_SEL    3'd1
`define EVB_HWR_PNUM   5'd0

// ==========================================
// Fields and reset values
`define EVB_BASE_LSB   12
`define EVB_WG_BIT     11
`define EVB_RSV_BIT    10
`define EVB_PNUM_MSB   9
`define EVB_CARRY_BIT  29
`define EVB_BASE_RST   20'h80000
`define EVB_LEGACY_HI  2'b10
`define EVB_SEG_NORMAL 3'b100
`define EVB_SEG_CACHE  3'b101

`endif

// [logic/evb_pkg.sv]
// Types shared by the exception vector base logic
`default_nettype none
package evb_pkg;
	typedef logic [31:0] evb_word_t;
	typedef enum logic [1:0] {
		EVB_VK_BASE  = 2'h0,
		EVB_VK_BOOT  = 2'h1,
		EVB_VK_DEBUG = 2'h3
	} evb_vec_kind_t;
endpackage
`default_nettype wire

// [logic/evb_sync.sv]
// Two-stage synchroniser for preset strap inputs
`default_nettype none
module evb_sync #(
	parameter int W = 10
) (
	input  wire logic         clk_sys_i, // System clock
	input  wire logic         rstn_i,    // Async reset, active low
	input  wire logic [W-1:0] async_i,   // Unsynchronised level
	output logic      [W-1:0] sync_o     // Synchronised level
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_i;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;
endmodule // evb_sync
`default_nettype wire

// [testbench/evb_core_model.sv]
// Core exception logic model that raises vector requests
`default_nettype none
module evb_core_model (
	input  wire logic        clk_sys_i, // System clock
	output logic             exc_req_o, // Vector request
	output logic             bsel_o,    // Boot vector select
	output logic             dbg_o,     // Debug exception
	output logic             cerr_o,    // Cache error exception
	output logic [15:0]      off_o      // Vector offset
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		exc_req_o = 1'b0;
		bsel_o    = 1'b1;
		dbg_o     = 1'b0;
		cerr_o    = 1'b0;
		off_o     = 16'h0000;
	end
	// ==========
	// One request; boot select back to one so base writes stay legal
	task automatic req(input logic b, d, c, input logic [15:0] o);
		@(posedge clk_sys_i);
		exc_req_o <= 1'b1;
		bsel_o    <= b;
		dbg_o     <= d;
		cerr_o    <= c;
		off_o     <= o;
		@(posedge clk_sys_i);
		exc_req_o <= 1'b0;
		bsel_o    <= 1'b1;
		off_o     <= ~o;
	endtask
endmodule // evb_core_model
`default_nettype wire

// [testbench/evb_exception_vector_base_tb_top.sv]
// Testbench for the exception vector base register and vector formation
`default_nettype none
module evb_exception_vector_base_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                   clk_sys_i, rstn_i, wr_en, rd_en, hw_en, req, bsel, dbg, cerr, v0, v1;
	logic [2:0]             sel;
	logic [4:0]             hnum, rnum;
	logic [9:0]             pnum;
	logic [15:0]            off;
	logic [31:0]            wdata, rd0, rd1, hw0, hw1, va0, va1;
	evb_pkg::evb_vec_kind_t k0, k1;
	int                     errors, compares;
	// ==========
	// Two builds: legacy form and write-gate form
	evb_exception_vector_base #(.WG_PRESENT(1'b0)) i_evb_exception_vector_base (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cop_wr_en_i(wr_en), .cop_rd_en_i(rd_en),
		.cop_reg_i(rnum), .cop_sel_i(sel), .cop_wr_data_i(wdata), .cop_rd_data_o(rd0),
		.hwr_rd_en_i(hw_en), .hwr_num_i(hnum), .hwr_rd_data_o(hw0),
		.processor_number_i(pnum), .exc_req_i(req), .boot_vector_select_i(bsel),
		.exc_debug_i(dbg), .exc_cache_err_i(cerr), .exc_offset_i(off), .vec_valid_o(v0),
		.vec_kind_o(k0), .vec_addr_o(va0));
	evb_exception_vector_base #(.WG_PRESENT(1'b1)) i_evb_exception_vector_base_wg (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cop_wr_en_i(wr_en), .cop_rd_en_i(rd_en),
		.cop_reg_i(rnum), .cop_sel_i(sel), .cop_wr_data_i(wdata), .cop_rd_data_o(rd1),
		.hwr_rd_en_i(hw_en), .hwr_num_i(hnum), .hwr_rd_data_o(hw1),
		.processor_number_i(pnum), .exc_req_i(req), .boot_vector_select_i(bsel),
		.exc_debug_i(dbg), .exc_cache_err_i(cerr), .exc_offset_i(off), .vec_valid_o(v1),
		.vec_kind_o(k1), .vec_addr_o(va1));
	evb_core_model i_evb_core_model (
		.clk_sys_i(clk_sys_i), .exc_req_o(req), .bsel_o(bsel), .dbg_o(dbg), .cerr_o(cerr),
		.off_o(off));
	// ==========
	// Access tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] s, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_en <= 1'b1;
		sel   <= s;
		wdata <= d;
		@(posedge clk_sys_i);
		wr_en <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [2:0] s, input logic [31:0] e0, e1);
		@(posedge clk_sys_i);
		rd_en <= 1'b1;
		sel   <= s;
		@(posedge clk_sys_i);
		rd_en <= 1'b0;
		#1;
		chk("read legacy", e0, rd0);
		chk("read gated", e1, rd1);
	endtask
	task automatic hrd(input logic [4:0] n, input logic [31:0] e);
		@(posedge clk_sys_i);
		hw_en <= 1'b1;
		hnum  <= n;
		@(posedge clk_sys_i);
		hw_en <= 1'b0;
		#1;
		chk("hw read legacy", e, hw0);
		chk("hw read gated", e, hw1);
	endtask
	task automatic vec(input logic b, d, c, input logic [15:0] o, input logic [31:0] e0, e1,
			input logic [1:0] k);
		i_evb_core_model.req(b, d, c, o);
		#1;
		chk("valid", 32'h1, {31'h0, v0 & v1});
		chk("addr legacy", e0, va0);
		chk("addr gated", e1, va1);
		chk("kind legacy", {30'h0, k}, {30'h0, k0});
		chk("kind gated", {30'h0, k}, {30'h0, k1});
		@(posedge clk_sys_i);
		#1;
		chk("valid low", 32'h0, {31'h0, v0 | v1});
	endtask
	task automatic test_done();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==========
	// Clock, watchdog and tests
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#(25 * 400);
		errors++;
		test_done();
	end
	initial begin
		errors   = 0;
		compares = 0;
		rstn_i   = 1'b0;
		wr_en    = 1'b0;
		rd_en    = 1'b0;
		hw_en    = 1'b0;
		sel      = 3'h1;
		hnum     = 5'h00;
		rnum     = 5'd15;
		pnum     = 10'h2a5;
		wdata    = 32'h0;
		repeat (5) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rd(3'h1, 32'h800002a5, 32'h800002a5);
		$display("test reset done");
		wr(3'h1, 32'h41234800);
		rd(3'h1, 32'h812342a5, 32'h41234aa5);
		vec(0, 0, 0, 16'h0180, 32'h81234180, 32'h41234180, 2'h0);
		vec(0, 0, 1, 16'h0100, 32'ha1234100, 32'h61234100, 2'h0);
		vec(1, 0, 0, 16'h0380, 32'hbfc00380, 32'hbfc00380, 2'h1);
		vec(1, 1, 0, 16'h0480, 32'hbfc00480, 32'hbfc00480, 2'h3);
		$display("test vectors done");
		// Offset overlaps the base on purpose so a carry would reach bit 30
		wr(3'h1, 32'h3ffff800);
		rd(3'h1, 32'hbffff2a5, 32'h3ffffaa5);
		vec(0, 0, 1, 16'h1000, 32'h80000000, 32'h00000000, 2'h0);
		$display("test carry done");
		wr(3'h1, 32'h80000000);
		rd(3'h1, 32'h800002a5, 32'h000002a5);
		wr(3'h0, 32'h12345800);
		rd(3'h1, 32'h800002a5, 32'h000002a5);
		rd(3'h0, 32'h800002a5, 32'h000002a5);
		rnum <= 5'd14;
		wr(3'h1, 32'h12345800);
		rnum <= 5'd15;
		rd(3'h1, 32'h800002a5, 32'h000002a5);
		$display("test gate done");
		vec(0, 0, 0, 16'h0000, 32'h80000000, 32'h00000000, 2'h0);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rd(3'h1, 32'h800002a5, 32'h800002a5);
		$display("test reset again done");
		hrd(5'h00, 32'h000002a5);
		hrd(5'h05, 32'h00000000);
		pnum <= 10'h15a;
		repeat (2) @(posedge clk_sys_i);
		hrd(5'h00, 32'h0000015a);
		$display("test hardware read done");
		test_done();
	end
endmodule // evb_exception_vector_base_tb_top
`default_nettype wire
